//--- gio_pair.sv
/*
 * Control and status logic for two internally routed general-purpose
 * lines, reached as an AHB-Lite slave. Holds the control register, a
 * set/clear interrupt event register and a set/clear mask register,
 * and drives one level interrupt.
 * Assumes: single-word transfers only, hsel decoded by the fabric,
 * line inputs asynchronous to clk, the pad or wiring outside resolves
 * each line from its output enable.
 */
// Implementation choice: register access over AHB-Lite.
`default_nettype none

`include "gio_defs.svh"

module gio_pair
   import gio_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic        hreadyout,
   output var  logic        hresp,
   output var  logic [31:0] hrdata,
   // Internal line A (three-signal two-way line)
   input  wire logic        aux_io_line_a_in,
   output var  logic        aux_io_line_a_out,
   output var  logic        aux_io_line_a_oe,
   // Internal line B (three-signal two-way line)
   input  wire logic        aux_io_line_b_in,
   output var  logic        aux_io_line_b_out,
   output var  logic        aux_io_line_b_oe,
   // Interrupt
   output var  logic        irq
);

   // Width of the event and mask registers, one bit per line
   localparam int unsigned NUM_LINES = 2;

   gio_state_s st;
   gio_state_s next_st;

   logic [1:0]  sw_evt_set;
   logic [1:0]  sw_evt_clr;
   logic [1:0]  hw_evt_set;
   logic        take;

   // Bit position of a control field for a given line
   function automatic int unsigned fpos(input int unsigned base, input int unsigned line);
      fpos = base + line * `GIO_LINE_STRIDE;
   endfunction : fpos

   // Control register image: reserved positions stay zero
   function automatic logic [31:0] ctrl_word(input gio_state_s s);
      logic [31:0] w;
      w = `GIO_CTRL_RESET;
      for (int unsigned i = 0; i < NUM_LINES; i++)
      begin
         // Logical input value, after polarity handling
         w[fpos(`GIO_DATA_BIT, i)] = s.sync2[i] ^ s.inv[i];
         w[fpos(`GIO_OE_BIT, i)]   = s.oe[i];
         w[fpos(`GIO_INV_BIT, i)]  = s.inv[i];
         w[fpos(`GIO_IE_BIT, i)]   = s.ie[i];
      end
      ctrl_word = w;
   endfunction : ctrl_word

   // Read multiplexer for all offsets; unmapped offsets read zero
   function automatic logic [31:0] read_word(input gio_state_s s);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (s.addr)
         `GIO_CTRL_OFS:
         begin
            w = ctrl_word(s);
         end
         `GIO_EVT_SET_OFS:
         begin
            w[1:0] = s.evt;
         end
         `GIO_EVT_CLR_OFS:
         begin
            w[1:0] = s.evt & s.mask;
         end
         `GIO_MASK_SET_OFS,
         `GIO_MASK_CLR_OFS:
         begin
            w[1:0] = s.mask;
         end
         default:
         begin
            w = 32'h0000_0000;
         end
      endcase
      read_word = w;
   endfunction : read_word

   // Address phase is taken only when the bus is ready and the transfer is real
   assign take = hsel & htrans[1] & hready;

   // Software set and clear strobes for the event register
   always_comb
   begin
      sw_evt_set = 2'h0;
      sw_evt_clr = 2'h0;
      if (st.bus == BUS_WRITE)
      begin
         if (st.addr == `GIO_EVT_SET_OFS)
         begin
            sw_evt_set = hwdata[1:0];
         end
         if (st.addr == `GIO_EVT_CLR_OFS)
         begin
            sw_evt_clr = hwdata[1:0];
         end
      end
   end

   // Level change on a synchronised line, gated by its enable
   always_comb
   begin
      hw_evt_set = 2'h0;
      for (int unsigned i = 0; i < NUM_LINES; i++)
      begin
         // Either direction of change counts once
         hw_evt_set[i] = (st.sync2[i] != st.prev[i]) & st.ie[i];
      end
   end

   // Next state of the whole block
   always_comb
   begin
      next_st = st;

      // Two-stage synchroniser, then one stage of history for change detect
      next_st.sync1 = {aux_io_line_b_in, aux_io_line_a_in};
      next_st.sync2 = st.sync1;
      next_st.prev  = st.sync2;

      // Response is always OKAY
      next_st.hresp = 1'b0;

      // Write data phase: apply hwdata to the addressed register
      if (st.bus == BUS_WRITE)
      begin
         case (st.addr)
            `GIO_CTRL_OFS:
            begin
               for (int unsigned i = 0; i < NUM_LINES; i++)
               begin
                  // Only the defined fields are stored; the rest is dropped
                  next_st.data_q[i] = hwdata[fpos(`GIO_DATA_BIT, i)];
                  next_st.oe[i]     = hwdata[fpos(`GIO_OE_BIT, i)];
                  next_st.inv[i]    = hwdata[fpos(`GIO_INV_BIT, i)];
                  next_st.ie[i]     = hwdata[fpos(`GIO_IE_BIT, i)];
               end
            end
            `GIO_MASK_SET_OFS:
            begin
               next_st.mask = st.mask | hwdata[1:0];
            end
            `GIO_MASK_CLR_OFS:
            begin
               next_st.mask = st.mask & ~hwdata[1:0];
            end
            default:
            begin
               next_st.mask = st.mask;
            end
         endcase
      end

      // Sticky events: a hardware set in the clearing cycle is kept
      next_st.evt = (st.evt & ~sw_evt_clr) | sw_evt_set | hw_evt_set;

      // Bus phase sequencing
      case (st.bus)
         BUS_READ:
         begin
            // One wait state, so writes just before are visible
            next_st.hrdata    = read_word(st);
            next_st.hreadyout = 1'b1;
            next_st.bus       = BUS_IDLE;
         end
         BUS_IDLE,
         BUS_WRITE:
         begin
            next_st.hreadyout = 1'b1;
            if (take)
            begin
               next_st.addr = haddr[7:0];
               if (hwrite)
               begin
                  next_st.bus = BUS_WRITE;
               end
               else
               begin
                  next_st.bus       = BUS_READ;
                  next_st.hreadyout = 1'b0;
               end
            end
            else
            begin
               next_st.bus = BUS_IDLE;
            end
         end
         default:
         begin
            next_st.bus       = BUS_IDLE;
            next_st.hreadyout = 1'b1;
         end
      endcase

      // Line drive: stored value through the polarity control
      for (int unsigned i = 0; i < NUM_LINES; i++)
      begin
         next_st.pin_out[i] = next_st.data_q[i] ^ next_st.inv[i];
      end

      // Level interrupt from unmasked events
      next_st.irq = |(next_st.evt & next_st.mask);
   end

   // State register; synchronous reset clears every control bit
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         st           <= '0;
         st.bus       <= BUS_IDLE;
         st.evt       <= `GIO_EVT_RESET;
         st.mask      <= `GIO_MASK_RESET;
         st.hreadyout <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Bus outputs straight from the state register
   assign hreadyout = st.hreadyout;
   assign hresp     = st.hresp;
   assign hrdata    = st.hrdata;

   // Line outputs stay inside the chip; enables gate the drive
   assign aux_io_line_a_out = st.pin_out[`GIO_EVT_LINE_A];
   assign aux_io_line_a_oe  = st.oe[`GIO_EVT_LINE_A];
   assign aux_io_line_b_out = st.pin_out[`GIO_EVT_LINE_B];
   assign aux_io_line_b_oe  = st.oe[`GIO_EVT_LINE_B];

   // Interrupt output
   assign irq = st.irq;

endmodule : gio_pair

`default_nettype wire

//--- gio_defs.svh
/*
 * Offsets, field positions, reset values and event layout of the
 * general-purpose line pair. Assumes the bus fabric decodes the
 * block's region and presents byte offsets in the low address bits.
 */
`ifndef GIO_DEFS_SVH
`define GIO_DEFS_SVH

// Register byte offsets within the block's window
`define GIO_CTRL_OFS      8'hfc
`define GIO_EVT_SET_OFS   8'h80
`define GIO_EVT_CLR_OFS   8'h84
`define GIO_MASK_SET_OFS  8'h88
`define GIO_MASK_CLR_OFS  8'h8c

// Control register field positions for line A; line B sits one stride up
`define GIO_DATA_BIT      16
`define GIO_OE_BIT        20
`define GIO_INV_BIT       21
`define GIO_IE_BIT        23
`define GIO_LINE_STRIDE   8

// Reset values
`define GIO_CTRL_RESET    32'h0000_0000
`define GIO_EVT_RESET     2'h0
`define GIO_MASK_RESET    2'h0

// Event register: bit 0 is the line A change, bit 1 the line B change
`define GIO_EVT_LINE_A    0
`define GIO_EVT_LINE_B    1

`endif

//--- gio_pkg.sv
/*
 * Types shared by the general-purpose line pair: bus phase states and
 * the packed state record of the block. Assumes gio_defs.svh is in the
 * include path.
 */
`default_nettype none

package gio_pkg;

   // Data phase of the register bus
   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_WRITE,
      BUS_READ
   } gio_bus_e;

   // Whole state of the block, one record
   typedef struct packed {
      gio_bus_e    bus;
      logic [7:0]  addr;
      logic [1:0]  data_q;
      logic [1:0]  oe;
      logic [1:0]  inv;
      logic [1:0]  ie;
      logic [1:0]  sync1;
      logic [1:0]  sync2;
      logic [1:0]  prev;
      logic [1:0]  evt;
      logic [1:0]  mask;
      logic [1:0]  pin_out;
      logic        hreadyout;
      logic        hresp;
      logic [31:0] hrdata;
      logic        irq;
   } gio_state_s;

endpackage : gio_pkg

`default_nettype wire

//--- gio_pair_assertions.sv
/* Port checker for gio_pair.
   Assumes one slave: hready is hreadyout. */
`default_nettype none
`include "gio_defs.svh"
module gio_pair_assertions (
   // Bus
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   // Lines, interrupt
   input wire logic        aux_io_line_a_out,
   input wire logic        aux_io_line_a_oe,
   input wire logic        aux_io_line_b_out,
   input wire logic        aux_io_line_b_oe,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       take;
   logic       rd_q;
   logic       wr_q;
   logic [7:0] a_q;
   logic       done;
   logic       irqr;
   // Data phase tracking
   assign take = hsel && htrans[1] && hready;
   assign done = rd_q && hreadyout;
   assign irqr = a_q inside {`GIO_EVT_SET_OFS, `GIO_EVT_CLR_OFS,
                             `GIO_MASK_SET_OFS, `GIO_MASK_CLR_OFS};
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         a_q  <= 8'h00;
      end
      else if (hready)
      begin
         rd_q <= take && !hwrite;
         wr_q <= take && hwrite;
         a_q  <= haddr[7:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("Read wait state wrong");
   a_write_nowait: assert property (take && hwrite |=> hreadyout)
      else $error("Write stalled");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("Response not okay");
   a_rdata_stands: assert property (!(rd_q && !hreadyout) |=> $stable(hrdata))
      else $error("Read data moved");
   a_rsvd_zero: assert property (done && a_q == `GIO_CTRL_OFS |->
      (hrdata & 32'h4e4e_ffff) == 32'h0) else $error("Reserved bit set");
   a_unmapped_zero: assert property (done && !irqr && a_q != `GIO_CTRL_OFS
      |-> hrdata == 32'h0) else $error("Unmapped read not zero");
   a_irq_narrow: assert property (done && irqr |-> hrdata[31:2] == 30'h0)
      else $error("Event read too wide");
   a_lines_hold: assert property (!wr_q |=> $stable({aux_io_line_a_oe,
      aux_io_line_a_out, aux_io_line_b_oe, aux_io_line_b_out})) else $error("Line moved");
   a_reset_clear: assert property (disable iff (1'b0) !resetn |=>
      !irq && !aux_io_line_a_oe && !aux_io_line_b_oe) else $error("Reset not clear");
   c_read: cover property (done && a_q == `GIO_CTRL_OFS);
   c_irq: cover property ($rose(irq));
   c_drive: cover property ($rose(aux_io_line_b_oe));
endmodule : gio_pair_assertions
bind gio_pair gio_pair_assertions u_chk (.clk(clk), .resetn(resetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .aux_io_line_a_out(aux_io_line_a_out), .aux_io_line_a_oe(aux_io_line_a_oe),
   .aux_io_line_b_out(aux_io_line_b_out), .aux_io_line_b_oe(aux_io_line_b_oe),
   .irq(irq));
`default_nettype wire

//--- gio_line_model.sv
/* Internal logic on the two lines.
   Assumes the bench sets what it drives while the block floats. */
`default_nettype none
module gio_line_model (
   // Block side
   input  wire logic [1:0] line_out,
   input  wire logic [1:0] line_oe,
   // Far side
   input  wire logic [1:0] far_drive,
   output var  logic [1:0] line_lvl
);
   timeunit 1ns;
   timeprecision 1ps;
   // Enabled block wins, internal logic drives otherwise
   always_comb
      for (int i = 0; i < 2; i++)
         line_lvl[i] = line_oe[i] ? line_out[i] : far_drive[i];
endmodule : gio_line_model
`default_nettype wire

//--- tb_top.sv
/* Self-checking bench for gio_pair.
   Assumes a single slave with hready looped back. */
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        hsel, hwrite, hreadyout, hresp, irq;
   logic        mon_rd = 1'b0;
   logic [31:0] haddr, hwdata, hrdata, w;
   logic [1:0]  htrans, ext, lvl, o, e, lv;
   logic [31:0] expq[$];
   int          error_cnt, checked, seed;
   // Clock
   always #2 clk = ~clk;
   gio_pair DUT (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .aux_io_line_a_in(lvl[0]), .aux_io_line_a_out(o[0]), .aux_io_line_a_oe(e[0]),
      .aux_io_line_b_in(lvl[1]), .aux_io_line_b_out(o[1]), .aux_io_line_b_oe(e[1]),
      .irq(irq));
   gio_line_model u_far (.line_out(o), .line_oe(e), .far_drive(ext), .line_lvl(lvl));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr  <= {24'h0, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
   endtask : xfer
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      expq.push_back(x);
      xfer(1'b0, a, 32'h0);
   endtask : rd
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : settle
   task automatic print_verdict;
      $display("Checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   // Read result monitor
   always @(posedge clk)
   begin
      if (mon_rd && hreadyout)
         check(hrdata, expq.pop_front());
      mon_rd <= resetn && (hreadyout ? hsel && htrans[1] && !hwrite : mon_rd);
   end
   // Watchdog
   initial
   begin
      #20000;
      error_cnt++;
      print_verdict();
   end
   // Main sequence
   initial
   begin
      {hsel, hwrite, haddr, htrans, hwdata, ext} = '0;
      seed = 32'h3450;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      settle(0);
      check(32'({irq, e, o}), 32'h0);
      rd(8'hfc, 32'h0);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk) ext <= 2'($random(seed));
         w = $random(seed);
         xfer(1'b1, 8'hfc, w);
         settle(3);
         check(32'(e), {30'h0, w[28], w[20]});
         check(32'(o), {30'h0, w[24] ^ w[29], w[16] ^ w[21]});
         // Line level from the rules: own drive when enabled, far side otherwise
         lv = {w[28] ? w[24] ^ w[29] : ext[1], w[20] ? w[16] ^ w[21] : ext[0]};
         rd(8'hfc, (w & 32'hb0b0_0000) |
            {7'h0, lv[1] ^ w[29], 7'h0, lv[0] ^ w[21], 16'h0});
      end
      xfer(1'b1, 8'h40, $random(seed));
      rd(8'h40, 32'h0);
      xfer(1'b1, 8'hfc, 32'h8080_0000);
      // Dropping the drive enables can move the lines; let that event land first
      settle(4);
      xfer(1'b1, 8'h84, 32'h3);
      xfer(1'b1, 8'h88, 32'h1);
      @(posedge clk) ext[0] <= ~ext[0];
      settle(4);
      check(32'(irq), 32'h1);
      rd(8'h80, 32'h1);
      xfer(1'b1, 8'h84, 32'h1);
      settle(0);
      check(32'(irq), 32'h0);
      @(posedge clk) ext[1] <= ~ext[1];
      settle(4);
      check(32'(irq), 32'h0);
      rd(8'h84, 32'h0);
      rd(8'h80, 32'h2);
      xfer(1'b1, 8'h80, 32'h1);
      rd(8'h80, 32'h3);
      xfer(1'b1, 8'h88, 32'h2);
      settle(0);
      check(32'(irq), 32'h1);
      xfer(1'b1, 8'h8c, 32'h3);
      settle(0);
      check(32'(irq), 32'h0);
      rd(8'h88, 32'h0);
      // Mid-run reset with drive, inversion, mask and events all set
      xfer(1'b1, 8'hfc, 32'hb0b0_0000);
      xfer(1'b1, 8'h88, 32'h3);
      xfer(1'b1, 8'h80, 32'h3);
      settle(0);
      check(32'({irq, e, o}), 32'h1f);
      @(posedge clk) resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      settle(0);
      check(32'({irq, e, o}), 32'h0);
      rd(8'h88, 32'h0);
      rd(8'h80, 32'h0);
      rd(8'hfc, {7'h0, ext[1], 7'h0, ext[0], 16'h0});
      settle(2);
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
